// File: rtl/gpib_msg_handler.sv
// Interface-message handler: addressing, remote/local, clear, trigger, poll
// Operation
// RULE1: While attention is high every byte is accepted as an interface command.
// RULE2: Device clear clears errors, aborts commands and sends, empties both buffers.
// RULE3: Without attention, a listener marks an end-flagged byte as message end.
// RULE4: Trigger while listening aborts and restarts the measurement.
// RULE5: Go-to-local while listening returns local, lockout kept.
// RULE6: Interface clear drops talker and listener, interface goes idle.
// RULE7: Own listen address makes the device a listener.
// RULE8: Own talk address makes the device a talker.
// RULE9: Lockout while remote disables the front panel local key.
// RULE10: Remote enable low returns local and clears lockout.
// RULE11: A null command changes nothing.
// RULE12: Remote enable high plus listen addressing puts the device in remote.
// RULE13: Selected clear while listening acts exactly like device clear.
// RULE14: In serial poll a talking device sends its status byte.
// RULE15: Unlisten releases the listener state.
// RULE16: Untalk drops the talker state and stops sending.
// RULE17: Another device's talk address drops our talker state.
// RULE18: Own talk address drops our listener state.
// RULE19: Own listen address drops our talker state.
// RULE20: The bus address is configurable and compared with every address byte.
module gpib_msg_handler
  import gpib_msg_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // Bus lines, sampled synchronously
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       atn,
  input  wire logic       eoi,
  input  wire logic       ifc,
  input  wire logic       ren,
  // Configuration and sources
  input  wire logic [4:0] bus_addr,
  input  wire logic       local_key,
  input  wire logic [7:0] status_byte,
  input  wire logic [7:0] meas_data,
  // Addressing state
  output logic            listener,
  output logic            talker,
  output logic            remote,
  output logic            lockout,
  output logic            poll_mode,
  output logic            local_key_en,
  // Actions
  output logic            clear_pulse,
  output logic            trigger_pulse,
  output logic            rx_data_valid,
  output logic            rx_data_last,
  output logic [7:0]      rx_data_out,
  output logic [7:0]      talk_data,
  output logic            talk_en
);

  typedef struct packed {
    logic       lacs;
    logic       tacs;
    rl_mode_t   mode;
    logic       llo;
    logic       spms;
    logic       clr;
    logic       trg;
    logic       dv;
    logic       dl;
    logic [7:0] dbyte;
    logic [7:0] tbyte;
    logic       rem;
    logic       ken;
  } state_t;

  state_t     st_ff;
  state_t     nxt_st;
  bus_byte_t  rx;
  cmd_dec_t   dec;
  logic [7:0] mux_byte;

  assign rx = '{valid: rx_valid, atn: atn, eoi: eoi, data: rx_data};

  gpib_cmd_decode u_dec (
    .rx      (rx),
    .my_addr (bus_addr),
    .dec     (dec)
  );

  gpib_talk_mux u_mux (
    // Registered select keeps the mux out of the next-state loop
    .poll_mode   (st_ff.spms),
    .status_byte (status_byte),
    .meas_data   (meas_data),
    .talk_data   (mux_byte)
  );

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.clr = RST_FLAG;
    nxt_st.trg = RST_FLAG;
    nxt_st.dv  = RST_FLAG;
    nxt_st.dl  = RST_FLAG;
    if (ifc) begin
      // Interface clear outranks every byte in the same cycle
      nxt_st.lacs = 1'b0; // RULE6
      nxt_st.tacs = 1'b0; // RULE6
      nxt_st.spms = 1'b0; // RULE6
    end else begin
      if (dec.my_listen) begin
        nxt_st.lacs = 1'b1; // RULE7
        nxt_st.tacs = 1'b0; // RULE19
      end
      if (dec.my_talk) begin
        nxt_st.tacs = 1'b1; // RULE8
        nxt_st.lacs = 1'b0; // RULE18
      end
      if (dec.other_talk)
        nxt_st.tacs = 1'b0; // RULE17
      if (dec.unlisten)
        nxt_st.lacs = 1'b0; // RULE15
      if (dec.untalk)
        nxt_st.tacs = 1'b0; // RULE16
      if (dec.dev_clear || (dec.sel_clear && st_ff.lacs))
        nxt_st.clr = 1'b1; // RULE2 RULE13
      if (dec.trigger && st_ff.lacs)
        nxt_st.trg = 1'b1; // RULE4
      if (dec.poll_en)
        nxt_st.spms = 1'b1; // RULE14
      if (dec.poll_dis)
        nxt_st.spms = 1'b0;
      if (dec.lockout)
        nxt_st.llo = 1'b1; // RULE9
      if (rx_valid && !atn && st_ff.lacs) begin
        nxt_st.dv    = 1'b1;
        nxt_st.dl    = eoi; // RULE3
        nxt_st.dbyte = rx_data;
      end
    end
    // Remote/local: remote enable low overrides everything
    if (!ren) begin
      nxt_st.mode = MODE_LOCAL; // RULE10
      nxt_st.llo  = 1'b0; // RULE10
    end else begin
      if (dec.my_listen && !ifc)
        nxt_st.mode = MODE_REMOTE; // RULE12
      if (dec.go_local && st_ff.lacs && !ifc)
        nxt_st.mode = MODE_LOCAL; // RULE5
      else if (local_key && st_ff.mode == MODE_REMOTE && !st_ff.llo)
        nxt_st.mode = MODE_LOCAL;
      if (nxt_st.mode != MODE_LOCAL && nxt_st.llo)
        nxt_st.mode = MODE_LOCKED; // RULE9
      else if (nxt_st.mode == MODE_LOCKED && !nxt_st.llo)
        nxt_st.mode = MODE_REMOTE;
    end
    nxt_st.tbyte = mux_byte; // RULE14
    // Mode decoded here so remote and key enable leave flip-flops
    nxt_st.rem   = nxt_st.mode != MODE_LOCAL;
    nxt_st.ken   = nxt_st.mode != MODE_LOCKED; // RULE9
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{lacs: RST_FLAG, tacs: RST_FLAG, mode: MODE_LOCAL, llo: RST_FLAG,
                 spms: RST_FLAG, clr: RST_FLAG, trg: RST_FLAG, dv: RST_FLAG,
                 dl: RST_FLAG, dbyte: RST_BYTE, tbyte: RST_BYTE, rem: RST_FLAG,
                 ken: !RST_FLAG};
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign listener      = st_ff.lacs;
  assign talker        = st_ff.tacs;
  assign remote        = st_ff.rem;
  assign lockout       = st_ff.llo;
  assign poll_mode     = st_ff.spms;
  assign local_key_en  = st_ff.ken; // RULE9
  assign clear_pulse   = st_ff.clr; // RULE2
  assign trigger_pulse = st_ff.trg; // RULE4
  assign rx_data_valid = st_ff.dv;
  assign rx_data_last  = st_ff.dl;
  assign rx_data_out   = st_ff.dbyte;
  assign talk_data     = st_ff.tbyte;
  assign talk_en       = st_ff.tacs; // RULE16

  chk_listen_own: assert property (@(posedge mclk) disable iff (!rst_n) // RULE7
    clk_en && !ifc && dec.my_listen |=> listener && !talker)
    else $error("own listen address not taken");

  chk_talk_own: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
    clk_en && !ifc && dec.my_talk |=> talker && !listener)
    else $error("own talk address not taken");

  chk_ifc_idle: assert property (@(posedge mclk) disable iff (!rst_n) // RULE6
    clk_en && ifc |=> !talker && !listener && !poll_mode)
    else $error("interface clear left addressing");

  chk_other_talk: assert property (@(posedge mclk) disable iff (!rst_n) // RULE17
    clk_en && (dec.other_talk || dec.untalk) |=> !talker && !talk_en)
    else $error("talker kept after other talk or untalk");

  chk_unlisten_drop: assert property (@(posedge mclk) disable iff (!rst_n) // RULE15
    clk_en && dec.unlisten |=> !listener)
    else $error("listener kept after unlisten");

  chk_clear_pulse: assert property (@(posedge mclk) disable iff (!rst_n) // RULE13
    clk_en && !ifc && dec.sel_clear && listener |=> clear_pulse ##1
      (!clear_pulse || !$past(clk_en) || $past(dec.dev_clear) || $past(dec.sel_clear)))
    else $error("selected clear gave no single pulse");

  chk_trig_gate: assert property (@(posedge mclk) disable iff (!rst_n) // RULE4
    clk_en && !ifc && dec.trigger |=> trigger_pulse == $past(listener))
    else $error("trigger not gated by listener");

  chk_ren_local: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
    clk_en && !ren |=> !remote && !lockout && local_key_en)
    else $error("remote enable low did not return local");

  chk_gtl_keep: assert property (@(posedge mclk) disable iff (!rst_n) // RULE5
    clk_en && ren && !ifc && dec.go_local && listener |=> !remote && lockout == $past(lockout))
    else $error("go to local mishandled");

  chk_eoi_last: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
    clk_en && !ifc && rx_valid && !atn && listener |=> rx_data_valid && rx_data_last == $past(eoi))
    else $error("end flag not carried");

  chk_null_quiet: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
    clk_en && !ifc && ren && !local_key && rx_valid && atn && rx_data[6:0] == CMD_NULL
    |=> $stable(listener) && $stable(talker) && $stable(remote) && $stable(lockout)
      && $stable(poll_mode) && !clear_pulse && !trigger_pulse && !rx_data_valid)
    else $error("null command changed state");

  chk_dcl_pulse: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
    clk_en && !ifc && dec.dev_clear
    |=> clear_pulse)
    else $error("device clear gave no pulse");

  chk_clear_cause: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
    clk_en && (ifc || !(dec.dev_clear || (dec.sel_clear && listener)))
    |=> !clear_pulse)
    else $error("clear pulse without a clear command");

  chk_sdc_refused: assert property (@(posedge mclk) disable iff (!rst_n) // RULE13
    clk_en && dec.sel_clear && !listener
    |=> !clear_pulse)
    else $error("selected clear taken while unaddressed");

  chk_trig_cause: assert property (@(posedge mclk) disable iff (!rst_n) // RULE4
    clk_en && (ifc || !(dec.trigger && listener))
    |=> !trigger_pulse)
    else $error("trigger pulse without a trigger");

  chk_lockout_set: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
    clk_en && !ifc && ren && dec.lockout
    |=> lockout)
    else $error("lockout not taken");

  chk_lockout_cause: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
    clk_en && !lockout && (ifc || !ren || !dec.lockout)
    |=> !lockout)
    else $error("lockout set without command");

  chk_key_disable: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
    local_key_en == !(remote && lockout))
    else $error("panel key enable wrong");

  chk_key_blocked: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
    clk_en && ren && remote && lockout && !(dec.go_local && listener && !ifc)
    |=> remote && lockout)
    else $error("locked out device left remote");

  chk_key_local: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
    clk_en && ren && local_key && remote && !lockout
    |=> !remote)
    else $error("panel key ignored while not locked");

  chk_ren_remote: assert property (@(posedge mclk) disable iff (!rst_n) // RULE12
    clk_en && !ifc && ren && dec.my_listen && !local_key
    |=> remote)
    else $error("listen address did not enter remote");

  chk_remote_cause: assert property (@(posedge mclk) disable iff (!rst_n) // RULE12
    clk_en && !remote && (ifc || !ren || !dec.my_listen)
    |=> !remote)
    else $error("remote entered without listen address");

  chk_poll_enter: assert property (@(posedge mclk) disable iff (!rst_n) // RULE14
    clk_en && !ifc && dec.poll_en
    |=> poll_mode)
    else $error("serial poll not entered");

  chk_poll_leave: assert property (@(posedge mclk) disable iff (!rst_n) // RULE14
    clk_en && (ifc || dec.poll_dis)
    |=> !poll_mode)
    else $error("serial poll not left");

  chk_poll_byte: assert property (@(posedge mclk) disable iff (!rst_n) // RULE14
    clk_en
    |=> talk_data == ($past(poll_mode) ? $past(status_byte) : $past(meas_data)))
    else $error("wrong talk source");

  chk_listen_cause: assert property (@(posedge mclk) disable iff (!rst_n) // RULE7
    clk_en && !listener && (ifc || !dec.my_listen)
    |=> !listener)
    else $error("listener without own listen address");

  chk_talk_cause: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
    clk_en && !talker && (ifc || !dec.my_talk)
    |=> !talker)
    else $error("talker without own talk address");

  chk_data_refused: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
    clk_en && (ifc || atn || !rx_valid || !listener)
    |=> !rx_data_valid && !rx_data_last)
    else $error("data byte taken while refused");

  chk_data_byte: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
    clk_en && !ifc && rx_valid && !atn && listener
    |=> rx_data_out == $past(rx_data))
    else $error("data byte not passed on");

  chk_cmd_not_data: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
    clk_en && rx_valid && atn
    |=> !rx_data_valid)
    else $error("command byte passed as data");

  chk_ifc_quiet: assert property (@(posedge mclk) disable iff (!rst_n) // RULE6
    clk_en && ifc
    |=> !clear_pulse && !trigger_pulse && !rx_data_valid)
    else $error("activity during interface clear");

  chk_other_listen: assert property (@(posedge mclk) disable iff (!rst_n) // RULE17
    clk_en && !ifc && dec.other_talk
    |=> $stable(listener))
    else $error("other talk address moved listener");

  chk_unlisten_talk: assert property (@(posedge mclk) disable iff (!rst_n) // RULE15
    clk_en && !ifc && dec.unlisten
    |=> $stable(talker))
    else $error("unlisten moved talker");

  chk_untalk_listen: assert property (@(posedge mclk) disable iff (!rst_n) // RULE16
    clk_en && !ifc && dec.untalk
    |=> $stable(listener))
    else $error("untalk moved listener");

  chk_gtl_refused: assert property (@(posedge mclk) disable iff (!rst_n) // RULE5
    clk_en && !ifc && ren && !local_key && dec.go_local && !listener
    |=> $stable(remote))
    else $error("go to local taken while unaddressed");

endmodule

// File: common/gpib_msg_pkg.sv
// Package: command codes, field layouts, states and carrier structs
package gpib_msg_pkg;

  // Multiline interface command codes (low seven bits of the data byte)
  localparam logic [6:0] CMD_GTL  = 7'h01;
  localparam logic [6:0] CMD_SDC  = 7'h04;
  localparam logic [6:0] CMD_GET  = 7'h08;
  localparam logic [6:0] CMD_LLO  = 7'h11;
  localparam logic [6:0] CMD_DCL  = 7'h14;
  localparam logic [6:0] CMD_SPE  = 7'h18;
  localparam logic [6:0] CMD_SPD  = 7'h19;
  localparam logic [6:0] CMD_NULL = 7'h00;
  localparam logic [6:0] CMD_UNL  = 7'h3f;
  localparam logic [6:0] CMD_UNT  = 7'h5f;

  // Address field layout within a command byte
  localparam int ADDR_LSB   = 0;
  localparam int ADDR_W     = 5;
  localparam int GROUP_LSB  = 5;
  localparam int GROUP_W    = 2;
  localparam logic [1:0] GROUP_LISTEN = 2'h1;
  localparam logic [1:0] GROUP_TALK   = 2'h2;

  // Reset values
  localparam logic       RST_FLAG   = 1'h0;
  localparam logic [7:0] RST_BYTE   = 8'h00;

  typedef enum logic [1:0] {
    MODE_LOCAL  = 2'b00,
    MODE_REMOTE = 2'b01,
    MODE_LOCKED = 2'b10
  } rl_mode_t;

  // One byte from the bus acceptor
  typedef struct packed {
    logic       valid;
    logic       atn;
    logic       eoi;
    logic [7:0] data;
  } bus_byte_t;

  // Decoded command strobes
  typedef struct packed {
    logic my_listen;
    logic my_talk;
    logic other_talk;
    logic unlisten;
    logic untalk;
    logic dev_clear;
    logic sel_clear;
    logic trigger;
    logic go_local;
    logic lockout;
    logic poll_en;
    logic poll_dis;
  } cmd_dec_t;

  // Action pulses toward the instrument
  typedef struct packed {
    logic clear;
    logic trigger;
    logic data_valid;
    logic data_last;
  } act_t;

endpackage

// File: rtl/gpib_cmd_decode.sv
// Decoder: turns an attention byte into command strobes
module gpib_cmd_decode
  import gpib_msg_pkg::*;
(
  // Byte in
  input  wire bus_byte_t        rx,
  input  wire logic [4:0]       my_addr,
  // Strobes out
  output cmd_dec_t              dec
);

  logic [1:0] grp;
  logic [4:0] fld;
  logic       cmd;

  always_comb begin
    grp = rx.data[GROUP_LSB +: GROUP_W];
    fld = rx.data[ADDR_LSB +: ADDR_W];
    cmd = rx.valid & rx.atn; // RULE1
    dec = '0; // RULE11
    // Address 31 codes are unlisten/untalk, never an address
    dec.unlisten   = cmd && rx.data[6:0] == CMD_UNL; // RULE15
    dec.untalk     = cmd && rx.data[6:0] == CMD_UNT; // RULE16
    dec.my_listen  = cmd && grp == GROUP_LISTEN && fld != 5'h1f && fld == my_addr; // RULE20
    dec.my_talk    = cmd && grp == GROUP_TALK && fld != 5'h1f && fld == my_addr; // RULE20
    dec.other_talk = cmd && grp == GROUP_TALK && fld != 5'h1f && fld != my_addr; // RULE17
    dec.dev_clear  = cmd && rx.data[6:0] == CMD_DCL;
    dec.sel_clear  = cmd && rx.data[6:0] == CMD_SDC;
    dec.trigger    = cmd && rx.data[6:0] == CMD_GET;
    dec.go_local   = cmd && rx.data[6:0] == CMD_GTL;
    dec.lockout    = cmd && rx.data[6:0] == CMD_LLO;
    dec.poll_en    = cmd && rx.data[6:0] == CMD_SPE;
    dec.poll_dis   = cmd && rx.data[6:0] == CMD_SPD;
    // A null byte matches nothing above and so leaves all strobes low
  end

endmodule

// File: rtl/gpib_talk_mux.sv
// Talk source select: status byte during serial poll, else measurement data
module gpib_talk_mux
  import gpib_msg_pkg::*;
(
  // Select
  input  wire logic       poll_mode,
  // Sources
  input  wire logic [7:0] status_byte,
  input  wire logic [7:0] meas_data,
  // Chosen byte
  output logic [7:0]      talk_data
);

  always_comb begin
    talk_data = poll_mode ? status_byte : meas_data; // RULE14
  end

endmodule

// File: test/gpib_ctl_model.sv
// Bus controller model: sends bytes and drives the ren and ifc levels
module gpib_ctl_model (
  // Clock
  input  wire logic  mclk,
  // Lines toward the handler
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       atn,
  output logic       eoi,
  output logic       ifc,
  output logic       ren
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {rx_valid, atn, eoi, ifc, ren} = 5'h00;
    rx_data = 8'h5a;
  end

  // One byte per call; a gap cycle follows each byte
  task automatic send(input logic a, input logic e, input logic [7:0] d);
    @(negedge mclk);
    {rx_valid, atn, eoi, rx_data} = {1'b1, a, e, d};
    @(negedge mclk);
    // Released lines must not keep showing the byte
    {rx_valid, eoi, rx_data} = {1'b0, 1'b0, ~d};
  endtask

  task automatic lines(input logic i, input logic r);
    @(negedge mclk);
    {ifc, ren} = {i, r};
  endtask
endmodule

// File: test/ieee488_interface_message_handler_tb.sv
// Testbench: addressing, remote/local, clear, trigger and poll checks
module ieee488_interface_message_handler_tb
  import gpib_msg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk = 1'b0;
  logic       rst_n, clk_en, local_key, rx_valid, atn, eoi, ifc, ren;
  logic [4:0] bus_addr, me, oth;
  logic [7:0] status_byte, meas_data, rx_data, rx_data_out, talk_data, seed, d;
  logic       listener, talker, remote, lockout, poll_mode, local_key_en, talk_en;
  logic       clear_pulse, trigger_pulse, rx_data_valid, rx_data_last;
  logic [7:0] st, pl;
  int         n_errors = 0;
  int         comparisons = 0;
  int         cycles = 0;

  assign st = {2'h0, listener, talker, remote, lockout, poll_mode, local_key_en};
  assign pl = {4'h0, clear_pulse, trigger_pulse, rx_data_valid, rx_data_last};

  always #2.5 mclk = ~mclk;

  gpib_ctl_model ctl (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data), .atn(atn),
    .eoi(eoi), .ifc(ifc), .ren(ren));

  gpib_msg_handler dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .rx_valid(rx_valid),
    .rx_data(rx_data), .atn(atn), .eoi(eoi), .ifc(ifc), .ren(ren), .bus_addr(bus_addr),
    .local_key(local_key), .status_byte(status_byte), .meas_data(meas_data),
    .listener(listener), .talker(talker), .remote(remote), .lockout(lockout),
    .poll_mode(poll_mode), .local_key_en(local_key_en), .clear_pulse(clear_pulse),
    .trigger_pulse(trigger_pulse), .rx_data_valid(rx_data_valid),
    .rx_data_last(rx_data_last), .rx_data_out(rx_data_out), .talk_data(talk_data),
    .talk_en(talk_en));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Expected state; the panel key is only blocked while remote and locked out
  function automatic logic [7:0] es(input logic l, t, r, k, p);
    return {2'h0, l, t, r, k, p, ~(r & k)};
  endfunction

  function automatic logic [7:0] ad(input logic [1:0] g, input logic [4:0] a);
    return {1'b0, g, a};
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Send one byte, then compare state and action pulses in the answer cycle
  task automatic xf(input logic a, e, input logic [7:0] b, s, p);
    ctl.send(a, e, b);
    check("state", st, s);
    check("pulses", pl, p);
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    {rst_n, local_key, bus_addr, status_byte, meas_data} = '0;
    clk_en = 1'b1;
    seed = 8'h40;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    check("state", st, es(0, 0, 0, 0, 0));
    ctl.lines(1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      // Address edges first: 30 wraps the neighbour to 0
      me = (i == 0) ? 5'd30 : (i == 1) ? 5'd0 : 5'(seed % 8'd31);
      oth = (me == 5'd30) ? 5'd0 : me + 5'd1;
      bus_addr = me;
      meas_data = lfsr(seed);
      status_byte = ~seed;
      d = lfsr(meas_data);
      xf(1, 0, ad(GROUP_LISTEN, me), es(1, 0, 1, 0, 0), 8'h00);
      xf(1, 0, {1'b0, CMD_NULL}, es(1, 0, 1, 0, 0), 8'h00);
      xf(1, 0, ad(GROUP_LISTEN, oth), es(1, 0, 1, 0, 0), 8'h00);
      xf(1, 0, ad(GROUP_TALK, me), es(0, 1, 1, 0, 0), 8'h00);
      check("talk_data", talk_data, meas_data);
      xf(1, 0, ad(GROUP_TALK, oth), es(0, 0, 1, 0, 0), 8'h00);
      xf(1, 0, ad(GROUP_TALK, me), es(0, 1, 1, 0, 0), 8'h00);
      check("talk_en", talk_en, 8'h01);
      xf(1, 0, ad(GROUP_LISTEN, me), es(1, 0, 1, 0, 0), 8'h00);
      xf(1, 0, {1'b0, CMD_GET}, es(1, 0, 1, 0, 0), 8'h04);
      xf(0, 1, d, es(1, 0, 1, 0, 0), 8'h03);
      check("rx_data_out", rx_data_out, d);
      xf(0, 0, ~d, es(1, 0, 1, 0, 0), 8'h02);
      xf(1, 0, {1'b0, CMD_DCL}, es(1, 0, 1, 0, 0), 8'h08);
      xf(1, 0, {1'b0, CMD_SDC}, es(1, 0, 1, 0, 0), 8'h08);
      xf(1, 0, {1'b0, CMD_LLO}, es(1, 0, 1, 1, 0), 8'h00);
      @(negedge mclk);
      local_key = 1'b1;
      @(negedge mclk);
      local_key = 1'b0;
      check("state", st, es(1, 0, 1, 1, 0));
      xf(1, 0, {1'b0, CMD_GTL}, es(1, 0, 0, 1, 0), 8'h00);
      xf(1, 0, ad(GROUP_LISTEN, me), es(1, 0, 1, 1, 0), 8'h00);
      ctl.lines(1'b0, 1'b0);
      @(negedge mclk);
      check("state", st, es(1, 0, 0, 0, 0));
      ctl.lines(1'b0, 1'b1);
      xf(1, 0, ad(GROUP_TALK, me), es(0, 1, 0, 0, 0), 8'h00);
      xf(1, 0, {1'b0, CMD_UNT}, es(0, 0, 0, 0, 0), 8'h00);
      check("talk_en", talk_en, 8'h00);
      xf(1, 0, {1'b0, CMD_SPE}, es(0, 0, 0, 0, 1), 8'h00);
      xf(1, 0, ad(GROUP_TALK, me), es(0, 1, 0, 0, 1), 8'h00);
      check("talk_data", talk_data, status_byte);
      xf(1, 0, {1'b0, CMD_SPD}, es(0, 1, 0, 0, 0), 8'h00);
      xf(1, 0, ad(GROUP_LISTEN, me), es(1, 0, 1, 0, 0), 8'h00);
      @(negedge mclk);
      local_key = 1'b1;
      @(negedge mclk);
      local_key = 1'b0;
      check("state", st, es(1, 0, 0, 0, 0));
      xf(1, 0, ad(GROUP_LISTEN, me), es(1, 0, 1, 0, 0), 8'h00);
      xf(1, 0, {1'b0, CMD_UNL}, es(0, 0, 1, 0, 0), 8'h00);
      xf(1, 0, {1'b0, CMD_GTL}, es(0, 0, 1, 0, 0), 8'h00);
      // Unaddressed: selected clear, trigger and data bytes are all refused
      xf(1, 0, {1'b0, CMD_SDC}, es(0, 0, 1, 0, 0), 8'h00);
      xf(1, 0, {1'b0, CMD_GET}, es(0, 0, 1, 0, 0), 8'h00);
      xf(0, 1, d, es(0, 0, 1, 0, 0), 8'h00);
      xf(1, 0, ad(GROUP_TALK, me), es(0, 1, 1, 0, 0), 8'h00);
      ctl.lines(1'b1, 1'b1);
      @(negedge mclk);
      check("state", st, es(0, 0, 1, 0, 0));
      xf(1, 0, ad(GROUP_LISTEN, me), es(0, 0, 1, 0, 0), 8'h00);
      ctl.lines(1'b0, 1'b1);
      // Frozen cycle: a byte offered while the enable is low is lost
      clk_en = 1'b0;
      xf(1, 0, ad(GROUP_LISTEN, me), es(0, 0, 1, 0, 0), 8'h00);
      clk_en = 1'b1;
    end
    summarize();
  end
endmodule
